// ---- core/dit_timer.sv ----
`timescale 1ns/1ps
`include "dit_params.svh"
// Operation
// - Write to timer A low counter stores byte in low latch only; moved on high write.
// - Reading timer A low counter returns counter low byte and clears timer A flag.
// - Writing timer A high counter loads high latch, counter from latches, starts, clears flag.
// - Reads of timer A high counter or high latch return counter high byte.
// - Write to timer A low latch acts as low counter write.
// - Reading timer A low latch returns latch low byte, flag unchanged.
// - Writing timer A high latch updates only that latch and clears timer A flag.
// - Control bits 7:6 pick one-shot or continuous, and wave pin use.
// - Control bit 5 picks timer B interval or pulse counting.
// - Control bits 4:2 store shifter mode for the serial shifter.
// - Timer A decrements from the clock after the high write, once per clock.
// - One-shot timer A flags once per load, on reaching zero.
// - One-shot with wave enabled: pin low after high write, high at zero.
// - Timer A flag clears on low counter read, high writes, or flag register write with bit 6 set.
// - Free-run at zero: set flag, toggle wave pin, reload 16-bit latch, continue.
// - Rewriting timer A high counter before zero restarts the full period.
// - Latch-only writes leave a running count alone; they set the next period.
// - Timer B is a 16-bit counter decrementing each clock in interval mode.
// - Timer B low write stores byte in low latch; counter untouched.
// - Timer B low read returns counter low byte and clears timer B flag.
// - Timer B high write loads high byte, low latch to low byte, clears flag.
// - Timer B high read returns counter high byte, no side effects.
// - Timer A zero sets flag bit 6; interrupt output low when enabled.
// - Interval timer B flags at zero, wraps to all ones, no reflag till reload.
// - Pulse mode: timer B decrements once per negative pulse held low at edge.
module dit_timer #(
  parameter int ADR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_pulse_pin,
  output logic o_wave_pin,
  output logic o_wave_oe,
  output logic o_irq_n,
  output logic [2:0] o_shift_mode,
  output logic [1:0] o_port_latch_en
);
  import dit_pkg::*;

  // =====================================================================
  // Bus request decode
  dit_req_type req;
  logic req_v;
  logic [7:0] wdata;

  function automatic logic hit(input dit_req_type r, input logic [3:0] idx, input logic wr);
    hit = (r.idx == idx) && (r.we == wr) && (wr ? r.lane0 : 1'b1);
  endfunction

  assign req = '{idx: i_wb_adr[5:2], we: i_wb_we, lane0: i_wb_sel[0], data: i_wb_dat[7:0]};
  assign wdata = req.data;

  logic ack_q;
  logic take;
  // One wait state; read data latched while ack is still low
  assign take = i_ce && i_wb_cyc && i_wb_stb && (i_wb_adr[ADR_W-1:6] == '0);
  // Effects land on the edge that samples ack, so a dropped cycle changes nothing
  assign req_v = take && ack_q;

  logic wr_a_lo, wr_a_hi, wr_a_llo, wr_a_lhi, wr_b_lo, wr_b_hi, wr_aux, wr_flag, wr_en;
  logic rd_a_lo, rd_b_lo;
  assign wr_a_lo = req_v && hit(req, `DIT_IDX_A_CNT_LO, 1'b1);
  assign wr_a_hi = req_v && hit(req, `DIT_IDX_A_CNT_HI, 1'b1);
  assign wr_a_llo = req_v && hit(req, `DIT_IDX_A_LAT_LO, 1'b1);
  assign wr_a_lhi = req_v && hit(req, `DIT_IDX_A_LAT_HI, 1'b1);
  assign wr_b_lo = req_v && hit(req, `DIT_IDX_B_LO, 1'b1);
  assign wr_b_hi = req_v && hit(req, `DIT_IDX_B_CNT_HI, 1'b1);
  assign wr_aux = req_v && hit(req, `DIT_IDX_AUX_CTRL, 1'b1);
  assign wr_flag = req_v && hit(req, `DIT_IDX_IRQ_FLAG, 1'b1);
  assign wr_en = req_v && hit(req, `DIT_IDX_IRQ_EN, 1'b1);
  assign rd_a_lo = req_v && hit(req, `DIT_IDX_A_CNT_LO, 1'b0);
  assign rd_b_lo = req_v && hit(req, `DIT_IDX_B_LO, 1'b0);

  // =====================================================================
  // Control registers
  dit_aux_type aux_q;
  logic [7:0] irq_en_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux_q <= dit_aux_type'(`DIT_AUX_RESET);
    end else if (wr_aux) begin
      aux_q <= dit_aux_type'(wdata);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en_q <= `DIT_EN_RESET;
    end else if (wr_en) begin
      irq_en_q <= wdata;
    end
  end

  logic a_cont;
  logic wave_en;
  assign a_cont = aux_q.a_mode[0];
  assign wave_en = aux_q.a_mode[1];

  // =====================================================================
  // Timer A latches
  logic [7:0] a_lat_lo_q;
  logic [7:0] a_lat_hi_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_lat_lo_q <= `DIT_BYTE_ZERO;
    end else if (wr_a_lo || wr_a_llo) begin
      a_lat_lo_q <= wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_lat_hi_q <= `DIT_BYTE_ZERO;
    end else if (wr_a_hi || wr_a_lhi) begin
      a_lat_hi_q <= wdata;
    end
  end

  // =====================================================================
  // Timer A counter
  logic [15:0] a_cnt_q;
  logic a_armed_q;
  logic a_zero;
  logic a_fire;
  assign a_zero = (a_cnt_q == `DIT_CNT_ZERO);
  // Continuous mode fires on every zero, one-shot only while armed
  assign a_fire = i_ce && !wr_a_hi && a_zero && (a_cont || a_armed_q);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_cnt_q <= `DIT_CNT_RESET;
    end else if (i_ce) begin
      if (wr_a_hi) begin
        a_cnt_q <= {wdata, a_lat_lo_q};
      end else if (a_zero && a_cont) begin
        a_cnt_q <= {a_lat_hi_q, a_lat_lo_q};
      end else begin
        a_cnt_q <= a_cnt_q - `DIT_CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_armed_q <= 1'b0;
    end else if (wr_a_hi) begin
      a_armed_q <= 1'b1;
    end else if (a_fire) begin
      a_armed_q <= 1'b0;
    end
  end

  // =====================================================================
  // Wave pin
  logic wave_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wave_q <= 1'b1;
    end else if (i_ce) begin
      if (wr_a_hi) begin
        wave_q <= 1'b0;
      end else if (a_fire && a_cont) begin
        wave_q <= !wave_q;
      end else if (a_fire) begin
        wave_q <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Timer B
  logic [7:0] b_lat_lo_q;
  logic [15:0] b_cnt_q;
  logic b_armed_q;
  logic pulse_prev_q;
  logic b_step;
  logic b_fire;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_prev_q <= 1'b1;
    end else if (i_ce) begin
      pulse_prev_q <= i_pulse_pin;
    end
  end

  // A pulse counts once, on the first edge that sees the pin low
  assign b_step = aux_q.b_pulse_count ? (pulse_prev_q && !i_pulse_pin) : 1'b1;
  assign b_fire = i_ce && !wr_b_hi && b_step && b_armed_q && (b_cnt_q == `DIT_CNT_ONE);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      b_lat_lo_q <= `DIT_BYTE_ZERO;
    end else if (wr_b_lo) begin
      b_lat_lo_q <= wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      b_cnt_q <= `DIT_CNT_RESET;
    end else if (i_ce) begin
      if (wr_b_hi) begin
        b_cnt_q <= {wdata, b_lat_lo_q};
      end else if (b_step) begin
        b_cnt_q <= b_cnt_q - `DIT_CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      b_armed_q <= 1'b0;
    end else if (wr_b_hi) begin
      b_armed_q <= 1'b1;
    end else if (b_fire) begin
      b_armed_q <= 1'b0;
    end
  end

  // =====================================================================
  // Flags; a set in the same cycle as a clear wins
  logic flag_a_q;
  logic flag_b_q;
  logic clr_a;
  logic clr_b;
  assign clr_a = rd_a_lo || wr_a_hi || wr_a_lhi || (wr_flag && wdata[`DIT_BIT_FLAG_A]);
  assign clr_b = rd_b_lo || wr_b_hi || (wr_flag && wdata[`DIT_BIT_FLAG_B]);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_a_q <= 1'b0;
    end else if (i_ce) begin
      flag_a_q <= a_fire || (flag_a_q && !clr_a);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_b_q <= 1'b0;
    end else if (i_ce) begin
      flag_b_q <= b_fire || (flag_b_q && !clr_b);
    end
  end

  logic [7:0] flags;
  always_comb begin
    flags = `DIT_BYTE_ZERO;
    flags[`DIT_BIT_FLAG_A] = flag_a_q;
    flags[`DIT_BIT_FLAG_B] = flag_b_q;
  end

  // =====================================================================
  // Interrupt request pin, registered, from flags and enables
  logic irq_n_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_n_q <= 1'b1;
    end else if (i_ce) begin
      irq_n_q <= !(|(flags & irq_en_q));
    end
  end

  // =====================================================================
  // Read data and acknowledge
  logic [7:0] rd_byte;
  logic [31:0] dat_q;

  always_comb begin
    rd_byte = `DIT_BYTE_ZERO;
    unique case (req.idx)
      `DIT_IDX_A_CNT_LO: rd_byte = a_cnt_q[7:0];
      `DIT_IDX_A_CNT_HI: rd_byte = a_cnt_q[15:8];
      `DIT_IDX_A_LAT_LO: rd_byte = a_lat_lo_q;
      `DIT_IDX_A_LAT_HI: rd_byte = a_cnt_q[15:8];
      `DIT_IDX_B_LO: rd_byte = b_cnt_q[7:0];
      `DIT_IDX_B_CNT_HI: rd_byte = b_cnt_q[15:8];
      `DIT_IDX_AUX_CTRL: rd_byte = aux_q;
      `DIT_IDX_IRQ_FLAG: rd_byte = flags;
      `DIT_IDX_IRQ_EN: rd_byte = irq_en_q;
      default: rd_byte = `DIT_BYTE_ZERO;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dat_q <= `DIT_WORD_ZERO;
    end else if (i_ce && i_wb_cyc && i_wb_stb && !ack_q) begin
      // Unmapped or out-of-range addresses read as zero
      dat_q <= (take && !req.we) ? {24'h00_0000, rd_byte} : `DIT_WORD_ZERO;
    end
  end

  // =====================================================================
  // Outputs
  assign o_wb_ack = ack_q;
  assign o_wb_dat = dat_q;
  assign o_wave_pin = wave_q;
  assign o_wave_oe = wave_en;
  assign o_irq_n = irq_n_q;
  assign o_shift_mode = aux_q.shift_mode;
  assign o_port_latch_en = aux_q.latch_en;

endmodule // dit_timer

// ---- core/dit_params.svh ----
`ifndef DIT_PARAMS_SVH
`define DIT_PARAMS_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define DIT_IDX_A_CNT_LO 4'h4
`define DIT_IDX_A_CNT_HI 4'h5
`define DIT_IDX_A_LAT_LO 4'h6
`define DIT_IDX_A_LAT_HI 4'h7
`define DIT_IDX_B_LO 4'h8
`define DIT_IDX_B_CNT_HI 4'h9
`define DIT_IDX_AUX_CTRL 4'hb
`define DIT_IDX_IRQ_FLAG 4'hd
`define DIT_IDX_IRQ_EN 4'he

// =====================================================================
// Field positions and reset values
`define DIT_BIT_FLAG_A 6
`define DIT_BIT_FLAG_B 5
`define DIT_AUX_RESET 8'h00
`define DIT_EN_RESET 8'h00
`define DIT_CNT_RESET 16'h0000
`define DIT_CNT_ZERO 16'h0000
`define DIT_CNT_ONE 16'h0001
`define DIT_BYTE_ZERO 8'h00
`define DIT_WORD_ZERO 32'h0000_0000

`endif

// ---- core/dit_pkg.sv ----
package dit_pkg;

  // =====================================================================
  // Timer A behaviour, auxiliary control bits 7:6
  typedef enum logic [1:0] {
    DIT_A_ONESHOT = 2'b00,
    DIT_A_CONT = 2'b01,
    DIT_A_ONESHOT_PULSE = 2'b10,
    DIT_A_CONT_SQUARE = 2'b11
  } dit_amode_type;

  // =====================================================================
  // Auxiliary control register layout
  typedef struct packed {
    dit_amode_type a_mode;
    logic b_pulse_count;
    logic [2:0] shift_mode;
    logic [1:0] latch_en;
  } dit_aux_type;

  // =====================================================================
  // Wishbone request seen by the slave
  typedef struct packed {
    logic [3:0] idx;
    logic we;
    logic lane0;
    logic [7:0] data;
  } dit_req_type;

endpackage

// ---- sim/dit_timer_sva.sv ----
`timescale 1ns/1ps
// ====================================================
// Checker on the timer block ports
module dit_timer_sva #(
  parameter int ADR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_pulse_pin,
  input wire logic o_wave_pin,
  input wire logic o_wave_oe,
  input wire logic o_irq_n,
  input wire logic [2:0] o_shift_mode,
  input wire logic [1:0] o_port_latch_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire tk = i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce;
  // Writes take effect at the edge that sees ack high
  wire ak = i_wb_cyc && i_wb_stb && o_wb_ack && i_ce;
  wire wt = ak && i_wb_we && i_wb_sel[0];
  wire wa = wt && i_wb_adr == ADR_W'(8'h2c);
  property p_ack_next; tk |=> o_wb_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse; o_wb_ack && i_ce |=> !o_wb_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; $rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hi; o_wb_ack |-> o_wb_dat[31:8] == 24'h0; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
  property p_aux_out;
    wa |=> o_wave_oe == $past(i_wb_dat[7]) && o_shift_mode == $past(i_wb_dat[4:2])
      && o_port_latch_en == $past(i_wb_dat[1:0]);
  endproperty
  a_aux_out: assert property (p_aux_out) else $error("control outputs wrong");
  property p_aux_hold; !wa |=> $stable(o_shift_mode) && $stable(o_port_latch_en); endproperty
  a_aux_hold: assert property (p_aux_hold) else $error("control changed unwritten");
  property p_wave_low; wt && i_wb_adr == ADR_W'(8'h14) && o_wave_oe |=> ##1 !o_wave_pin; endproperty
  a_wave_low: assert property (p_wave_low) else $error("wave not low after load");
  property p_unmap; tk && !i_wb_we && i_wb_adr[ADR_W-1:6] != 0 |=> o_wb_dat == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_aux: cover property (wa);
  c_irq: cover property ($fell(o_irq_n));
  c_wave: cover property ($rose(o_wave_pin));
endmodule // dit_timer_sva

bind dit_timer dit_timer_sva #(.ADR_W(ADR_W)) u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
  .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pulse_pin(i_pulse_pin),
  .o_wave_pin(o_wave_pin), .o_wave_oe(o_wave_oe), .o_irq_n(o_irq_n), .o_shift_mode(o_shift_mode),
  .o_port_latch_en(o_port_latch_en));

// ---- sim/dit_pulse_src.sv ----
`timescale 1ns/1ps
// ====================================================
// Pulse source on the timer B pin
module dit_pulse_src (
  input wire logic i_clk,
  output logic o_pin
);
  initial o_pin = 1'b1;
  // Idle high; each pulse low across exactly one edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_pin <= 1'b0;
      @(posedge i_clk);
      o_pin <= 1'b1;
      repeat (2) @(posedge i_clk);
    end
  endtask
endmodule // dit_pulse_src

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module testbench;
  logic clk = 1'b0;
  logic rst_n, cyc, stb, we, pin, w1, ce;
  logic [7:0] adr, q, d;
  logic [3:0] sel;
  logic [31:0] dat, rdat;
  logic ack, wave, oe, irq_n;
  logic [2:0] shm;
  logic [1:0] lat;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  int i;
  always #2 clk = ~clk;
  dit_timer DUT (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_pulse_pin(pin),
    .o_wave_pin(wave), .o_wave_oe(oe), .o_irq_n(irq_n), .o_shift_mode(shm), .o_port_latch_en(lat));
  dit_pulse_src u_src (.i_clk(clk), .o_pin(pin));
  // ====================================================
  // Bus tasks
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] v, output logic [7:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, v};
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] r;
    wb(a, 1'b1, v, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    wb(a, 1'b0, 8'h00, r);
    `CHK(r, e)
  endtask
  // Bounded wait for the interrupt line
  task automatic wt(input logic v);
    int n;
    n = 0;
    while (irq_n !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    `CHK(irq_n, v)
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // ====================================================
  // Tests
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, adr, dat} = '0;
    ce = 1'b1;
    sel = 4'h1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK({wave, oe, irq_n, shm, lat}, 8'ha0)
    for (i = 0; i < 8; i++) begin
      d = {i[1:0], i[0], i[2:0], i[1:0]};
      wr(8'h2c, d);
      @(posedge clk);
      `CHK({oe, shm, lat}, {d[7], d[4:0]})
      rd(8'h2c, d);
    end
    rd(8'h40, 8'h00);
    rd(8'h04, 8'h00);
    wr(8'h80, 8'h00);
    `CHK(shm, 3'b111)
    $display("control done");
    wr(8'h2c, 8'h80);
    wr(8'h38, 8'h40);
    wr(8'h10, 8'h34);
    wr(8'h1c, 8'h12);
    rd(8'h18, 8'h34);
    wr(8'h18, 8'h56);
    wr(8'h14, 8'h12);
    @(posedge clk);
    `CHK(wave, 1'b0)
    rd(8'h10, 8'h54);
    wr(8'h1c, 8'h77);
    rd(8'h1c, 8'h12);
    rd(8'h14, 8'h12);
    rd(8'h18, 8'h56);
    wr(8'h10, 8'h30);
    repeat (5) begin
      wr(8'h14, 8'h00);
      repeat (20) @(posedge clk);
    end
    `CHK(irq_n, 1'b1)
    wt(1'b0);
    repeat (2) @(posedge clk);
    `CHK(wave, 1'b1)
    wb(8'h10, 1'b0, 8'h00, q);
    wt(1'b1);
    repeat (60) @(posedge clk);
    `CHK(irq_n, 1'b1)
    rd(8'h14, 8'hff);
    $display("one-shot done");
    wr(8'h2c, 8'hc0);
    wr(8'h14, 8'h00);
    wt(1'b0);
    repeat (2) @(posedge clk);
    w1 = wave;
    wr(8'h1c, 8'h00);
    wt(1'b1);
    wt(1'b0);
    repeat (2) @(posedge clk);
    `CHK(wave, ~w1)
    wr(8'h34, 8'h40);
    wt(1'b1);
    $display("free-run done");
    wr(8'h2c, 8'h00);
    wr(8'h38, 8'h20);
    wr(8'h34, 8'h60);
    wr(8'h20, 8'h10);
    wr(8'h24, 8'h00);
    // Frozen clock enable must hold off the time-out
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    `CHK(irq_n, 1'b1)
    ce <= 1'b1;
    rd(8'h24, 8'h00);
    wt(1'b0);
    wb(8'h20, 1'b0, 8'h00, q);
    wt(1'b1);
    repeat (40) @(posedge clk);
    `CHK(irq_n, 1'b1)
    rd(8'h24, 8'hff);
    wr(8'h2c, 8'h20);
    wr(8'h20, 8'h03);
    wr(8'h24, 8'h00);
    u_src.pulses(2);
    rd(8'h20, 8'h01);
    `CHK(irq_n, 1'b1)
    u_src.pulses(1);
    wt(1'b0);
    rd(8'h20, 8'h00);
    $display("timer b done");
    final_report();
  end
endmodule // testbench
